// ---- sensor_alarm_cfg.svh ----
`ifndef SENSOR_ALARM_CFG_SVH
`define SENSOR_ALARM_CFG_SVH
`define REG_CTRL 8'h00
`define REG_HI_TRIP 8'h04
`define REG_HI_HYST 8'h08
`define REG_LO_TRIP 8'h0c
`define REG_LO_HYST 8'h10
`define REG_MEAS 8'h14
`define REG_STATUS 8'h18
`define REG_MASK 8'h1c
`define REG_DEV_ADDR 8'h20
`define REG_RES 8'h24
`define CTRL_HI_POL 0
`define CTRL_HI_OD 1
`define CTRL_LO_POL 2
`define CTRL_LO_OD 3
`define CTRL_DIFF 4
`define CTRL_PHASE 5
`define CTRL_LOCK 6
`define CTRL_READY_OD 7
`define CTRL_SEL_LSB 8
`define CTRL_UPDATE 10
`define CTRL_RESET 32'h0000_0400
`define DEV_ADDR_RESET 7'h28
`define RES_RESET 4'h0
`define ST_DONE 0
`define ST_HI 1
`define ST_LO 2
`endif

// ---- sensor_alarm_pkg.sv ----
package sensor_alarm_pkg;
    typedef enum logic [1:0] {
        out_i2c,
        out_spi,
        out_density,
        out_density_cap
    } out_sel_e;
    typedef struct packed {
        logic pol;
        logic od;
    } alarm_drive_s;
    typedef struct packed {
        logic [15:0] trip;
        logic [15:0] hyst;
    } alarm_cfg_s;
endpackage : sensor_alarm_pkg

// ---- sensor_output_alarm_config.sv ----
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
`include "sensor_alarm_cfg.svh"

// Notes on behaviour
// - high alarm asserts when measurement rises above high trip point.
// - low alarm asserts when measurement falls below low trip point.
// - density output selection takes over the shared low alarm pin.
// - polarity 0, open-drain 0: push-pull, high while alarm active.
// - one bit selects differential instead of single-ended input.
// - phase 1: output data changes on rising clock edge for host.
// - address lock off: acknowledge any two-wire target address.
// - done pin may be driven open-drain for wired sharing.
// - separate capacitance and temperature resolution, 10/12/14 bit.
// - done pin pulses when a new conversion result is available.
module sensor_output_alarm_config (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [15:0] meas_in,
    input wire logic meas_valid_in,
    input wire logic serial_clk_in,
    input wire logic [6:0] target_addr_in,
    output logic addr_match_out,
    output logic data_launch_out,
    output logic alarm_high_out,
    output logic alarm_high_oe_n_out,
    output logic alarm_low_out,
    output logic alarm_low_oe_n_out,
    output logic ready_out,
    output logic ready_oe_n_out,
    output logic diff_input_out,
    output logic update_mode_out,
    output logic [1:0] cap_res_out,
    output logic [1:0] temp_res_out,
    output logic density_active_out,
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////
    logic [31:0] ctrl, w_data, next_rdata;
    sensor_alarm_pkg::alarm_cfg_s hi_cfg;
    sensor_alarm_pkg::alarm_cfg_s lo_cfg;
    logic [15:0] meas;
    logic [2:0] status, mask;
    logic [6:0] dev_addr;
    logic [3:0] res, w_strb;
    logic hi_act, lo_act, done_pulse;
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic rd_status;
    logic sclk_s1, sclk_s2, sclk_d;
    sensor_alarm_pkg::out_sel_e sel;
    sensor_alarm_pkg::alarm_drive_s hi_drv, lo_drv;

    assign sel = sensor_alarm_pkg::out_sel_e'(ctrl[`CTRL_SEL_LSB +: 2]);
    assign hi_drv = '{pol: ctrl[`CTRL_HI_POL], od: ctrl[`CTRL_HI_OD]};
    assign lo_drv = '{pol: ctrl[`CTRL_LO_POL], od: ctrl[`CTRL_LO_OD]};

    ////////////////////////////////////////////////////////////////////
    // axi write: address and data latched independently
    assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
    assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;
    assign s_axi_bresp_out = 2'h0;
    assign s_axi_rresp_out = 2'h0;

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid_out <= 1'b0;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_in;
                w_strb <= s_axi_wstrb_in;
            end
            if (aw_held && w_held) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
            end else if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    logic wr_go;
    logic [31:0] m_ctrl, m_hi, m_lo, m_mask, m_addr, m_res, m_hh, m_lh;
    assign wr_go = aw_held && w_held;
    assign m_ctrl = merge(ctrl, w_data, w_strb);
    assign m_hi = merge({16'h0000, hi_cfg.trip}, w_data, w_strb);
    assign m_hh = merge({16'h0000, hi_cfg.hyst}, w_data, w_strb);
    assign m_lo = merge({16'h0000, lo_cfg.trip}, w_data, w_strb);
    assign m_lh = merge({16'h0000, lo_cfg.hyst}, w_data, w_strb);
    assign m_mask = merge({29'h0, mask}, w_data, w_strb);
    assign m_addr = merge({25'h0, dev_addr}, w_data, w_strb);
    assign m_res = merge({28'h0, res}, w_data, w_strb);

    // trip and hysteresis must be loaded by software first
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl <= `CTRL_RESET;
            hi_cfg <= '1;
            lo_cfg <= '0;
            mask <= 3'h0;
            dev_addr <= `DEV_ADDR_RESET;
            res <= `RES_RESET;
        end else if (wr_go) begin
            if (aw_addr == `REG_CTRL) begin
                ctrl <= {21'h0, m_ctrl[10:0]};
            end else if (aw_addr == `REG_HI_TRIP) begin
                hi_cfg.trip <= m_hi[15:0];
            end else if (aw_addr == `REG_HI_HYST) begin
                hi_cfg.hyst <= m_hh[15:0];
            end else if (aw_addr == `REG_LO_TRIP) begin
                lo_cfg.trip <= m_lo[15:0];
            end else if (aw_addr == `REG_LO_HYST) begin
                lo_cfg.hyst <= m_lh[15:0];
            end else if (aw_addr == `REG_MASK) begin
                mask <= m_mask[2:0];
            end else if (aw_addr == `REG_DEV_ADDR) begin
                dev_addr <= m_addr[6:0];
            end else if (aw_addr == `REG_RES) begin
                res <= m_res[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // axi read; unmapped reads return zero with okay
    assign s_axi_arready_out = !s_axi_rvalid_out;

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (s_axi_araddr_in == `REG_CTRL) begin
            next_rdata = ctrl;
        end else if (s_axi_araddr_in == `REG_HI_TRIP) begin
            next_rdata = {16'h0000, hi_cfg.trip};
        end else if (s_axi_araddr_in == `REG_HI_HYST) begin
            next_rdata = {16'h0000, hi_cfg.hyst};
        end else if (s_axi_araddr_in == `REG_LO_TRIP) begin
            next_rdata = {16'h0000, lo_cfg.trip};
        end else if (s_axi_araddr_in == `REG_LO_HYST) begin
            next_rdata = {16'h0000, lo_cfg.hyst};
        end else if (s_axi_araddr_in == `REG_MEAS) begin
            next_rdata = {14'h0, lo_act, hi_act, meas};
        end else if (s_axi_araddr_in == `REG_STATUS) begin
            next_rdata = {29'h0, status};
        end else if (s_axi_araddr_in == `REG_MASK) begin
            next_rdata = {29'h0, mask};
        end else if (s_axi_araddr_in == `REG_DEV_ADDR) begin
            next_rdata = {25'h0, dev_addr};
        end else if (s_axi_araddr_in == `REG_RES) begin
            next_rdata = {28'h0, res};
        end
    end

    assign rd_status = s_axi_arvalid_in && s_axi_arready_out &&
                       (s_axi_araddr_in == `REG_STATUS);

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
        end else if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= next_rdata;
        end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // alarm comparators with hysteresis
    logic [16:0] hi_clr_lvl, lo_clr_lvl;
    assign hi_clr_lvl = {1'b0, hi_cfg.trip} - {1'b0, hi_cfg.hyst};
    assign lo_clr_lvl = {1'b0, lo_cfg.trip} + {1'b0, lo_cfg.hyst};

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meas <= 16'h0000;
            hi_act <= 1'b0;
            lo_act <= 1'b0;
            done_pulse <= 1'b0;
        end else begin
            done_pulse <= meas_valid_in;
            if (meas_valid_in) begin
                meas <= meas_in;
                if (meas_in > hi_cfg.trip) begin
                    hi_act <= 1'b1;
                end else if (!hi_clr_lvl[16] &&
                             {1'b0, meas_in} <= hi_clr_lvl) begin
                    hi_act <= 1'b0;
                end
                if (meas_in < lo_cfg.trip) begin
                    lo_act <= 1'b1;
                end else if (!lo_clr_lvl[16] &&
                             {1'b0, meas_in} >= lo_clr_lvl) begin
                    lo_act <= 1'b0;
                end
            end
        end
    end

    // status set once the sample has settled; set wins over read clear
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            status <= 3'h0;
        end else begin
            status <= (rd_status ? 3'h0 : status) |
                      {lo_act & done_pulse, hi_act & done_pulse, done_pulse};
        end
    end
    assign irq_out = |(status & mask);

    ////////////////////////////////////////////////////////////////////
    // pin drivers; open drain drives only the low level and releases the pin when the level is high
    logic hi_lvl, lo_lvl;
    assign hi_lvl = hi_act ^ hi_drv.pol;
    assign lo_lvl = lo_act ^ lo_drv.pol;
    // density mode steals the low alarm pin
    assign density_active_out = sel[1];
    assign alarm_high_out = hi_drv.od ? 1'b0 : hi_lvl;
    assign alarm_high_oe_n_out = hi_drv.od ? hi_lvl : 1'b0;
    assign alarm_low_out = sel[1] ? 1'b0 : (lo_drv.od ? 1'b0 : lo_lvl);
    assign alarm_low_oe_n_out = sel[1] ? 1'b1 :
                                (lo_drv.od ? lo_lvl : 1'b0);
    // shared done line: open drain pulls low on done
    assign ready_out = ctrl[`CTRL_READY_OD] ? 1'b0 : done_pulse;
    assign ready_oe_n_out = ctrl[`CTRL_READY_OD] ? !done_pulse : 1'b0;

    assign diff_input_out = ctrl[`CTRL_DIFF];
    // forced update in density mode guards a host-less setup
    assign update_mode_out = ctrl[`CTRL_UPDATE] | sel[1];
    assign cap_res_out = res[1:0];
    assign temp_res_out = res[3:2];
    assign addr_match_out = !ctrl[`CTRL_LOCK] ||
                            (target_addr_in == dev_addr);

    ////////////////////////////////////////////////////////////////////
    // serial clock sampled; phase picks launch edge
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sclk_s1 <= 1'b1; // idle high: no false edge after reset
            sclk_s2 <= 1'b1;
            sclk_d <= 1'b1;
        end else begin
            sclk_s1 <= serial_clk_in;
            sclk_s2 <= sclk_s1;
            sclk_d <= sclk_s2;
        end
    end
    assign data_launch_out = ctrl[`CTRL_PHASE] ? (sclk_s2 & ~sclk_d) :
                             (~sclk_s2 & sclk_d);

    ////////////////////////////////////////////////////////////////////
    default clocking check_clk @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);
    a_hi_sets: assert property (
        meas_valid_in && meas_in > hi_cfg.trip |=> hi_act
    ) else $error("high alarm missed");
    a_lo_sets: assert property (
        meas_valid_in && meas_in < lo_cfg.trip |=> lo_act
    ) else $error("low alarm missed");
    a_hi_holds: assert property (
        hi_act && !(meas_valid_in && {1'b0, meas_in} + {1'b0, hi_cfg.hyst}
        <= {1'b0, hi_cfg.trip}) |=> hi_act
    ) else $error("high alarm dropped early");
    a_pin_pol: assert property (
        !hi_drv.od |-> alarm_high_out == (hi_act ^ hi_drv.pol)
    ) else $error("high pin polarity wrong");
    a_pushpull_en: assert property (
        !hi_drv.od |-> !alarm_high_oe_n_out
    ) else $error("push pull not driven");
    a_done_pulse: assert property (
        meas_valid_in && !ctrl[`CTRL_READY_OD] |=> ready_out
    ) else $error("done pin missed");
    a_od_ready: assert property (
        ctrl[`CTRL_READY_OD] |-> !ready_out
    ) else $error("open drain drove high");
    a_any_addr: assert property (
        !ctrl[`CTRL_LOCK] |-> addr_match_out
    ) else $error("unlocked address refused");
    a_density_pin: assert property (
        sel[1] |-> alarm_low_oe_n_out && update_mode_out
    ) else $error("density pin still driven");
    c_hi_trip: cover property ($rose(hi_act));
    c_lo_trip: cover property ($rose(lo_act));
    c_hi_release: cover property ($fell(hi_act));
    c_irq: cover property ($rose(irq_out));

endmodule : sensor_output_alarm_config

// ---- host_link_model.sv ----
`timescale 1ns/10ps

module host_link_model (
    input wire logic frame_in,
    input wire logic [6:0] addr_in,
    output logic serial_clk_out,
    output logic [6:0] target_addr_out
);
    // clock idles high between frames, as a pulled-up line would
    initial serial_clk_out = 1'b1;

    // host samples data on the falling edges of this clock
    // odd start delay keeps every link edge 0.5 ns after a system clock edge, never on one
    always begin
        @(posedge frame_in);
        #13;
        repeat (16) #40 serial_clk_out = ~serial_clk_out;
    end

    // a released address bus floats to the pull-up level
    assign target_addr_out = frame_in ? addr_in : 7'h7f;
endmodule : host_link_model

// ---- sensor_output_alarm_config_tb.sv ----
`timescale 1ns/10ps
`include "sensor_alarm_cfg.svh"

module sensor_output_alarm_config_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, cres, tres;
    logic [31:0] rdata;
    logic [15:0] meas = 16'h0;
    logic mvalid = 1'b0, frame = 1'b0, exp_level = 1'b0;
    logic [6:0] addr = 7'h00, taddr;
    logic sclk, match, launch, ahi, ahi_oe_n, alo, alo_oe_n;
    logic rdy, rdy_oe_n, diff, upd, dens, irq;
    int failures = 0, cmp_count = 0, launch_cnt = 0;
    logic [31:0] exp_q[$];

    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////
    sensor_output_alarm_config dut (
        .sys_clk_in(clk), .reset_n_in(rst_n),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .meas_in(meas),
        .meas_valid_in(mvalid), .serial_clk_in(sclk),
        .target_addr_in(taddr), .addr_match_out(match),
        .data_launch_out(launch), .alarm_high_out(ahi),
        .alarm_high_oe_n_out(ahi_oe_n), .alarm_low_out(alo),
        .alarm_low_oe_n_out(alo_oe_n), .ready_out(rdy),
        .ready_oe_n_out(rdy_oe_n), .diff_input_out(diff),
        .update_mode_out(upd), .cap_res_out(cres),
        .temp_res_out(tres), .density_active_out(dens),
        .irq_out(irq));

    host_link_model host (.frame_in(frame), .addr_in(addr),
        .serial_clk_out(sclk), .target_addr_out(taddr));

    ////////////////////////////////////////////////////////////
    task automatic check(input string n, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report

    // ready seen at the falling edge is the value sampled at the next rise
    task automatic wait_hi(input int k);
        logic t;
        do begin
            @(negedge clk);
            t = (k == 0) ? arready : (k == 1) ? rvalid : bvalid;
            @(posedge clk);
        end while (t !== 1'b1);
    endtask : wait_hi

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [3:0] st);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge clk);
            ta = ta || (awready === 1'b1);
            tw = tw || (wready === 1'b1);
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        wait_hi(2);
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        wait_hi(0);
        arvalid <= 1'b0;
        wait_hi(1);
        rready <= 1'b0;
    endtask : axi_read

    task automatic do_meas(input logic [15:0] v, input logic hi, lo, od);
        @(posedge clk);
        meas <= v;
        mvalid <= 1'b1;
        @(posedge clk);
        mvalid <= 1'b0;
        @(negedge clk);
        check("alarm_high", ahi, hi);
        check("alarm_high_oe", ahi_oe_n, 1'b0);
        check("alarm_low", alo, lo);
        check("ready_pulse", {rdy, rdy_oe_n}, {~od, 1'b0});
        @(negedge clk);
        check("ready_idle", rdy_oe_n, od);
    endtask : do_meas

    task automatic run_frame(input logic [6:0] a, input logic m);
        @(posedge clk);
        launch_cnt = 0;
        frame <= 1'b1;
        addr <= a;
        repeat (20) @(posedge clk);
        @(negedge clk);
        check("addr_match", match, m);
        repeat (130) @(posedge clk);
        frame <= 1'b0;
        check("launch_count", launch_cnt, 8);
    endtask : run_frame

    ////////////////////////////////////////////////////////////
    // results appear one at a time, so the oldest note is the right one
    always @(negedge clk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            check("rdata", rdata, exp_q.pop_front());
            check("rresp", rresp, 2'h0);
        end
        if (bvalid === 1'b1 && bready === 1'b1)
            check("bresp", bresp, 2'h0);
        if (launch === 1'b1) begin
            launch_cnt++;
            check("launch_level", sclk, exp_level);
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        final_report();
    end

    ////////////////////////////////////////////////////////////
    initial begin
        logic [3:0] res;
        logic [6:0] ra;
        void'($urandom(57887));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check("reset_pins", {alo_oe_n, upd, irq}, 3'b010);
        axi_read(`REG_CTRL, `CTRL_RESET);
        axi_read(`REG_HI_TRIP, 32'h0000_ffff);
        axi_read(`REG_DEV_ADDR, 32'h0000_0028);
        axi_read(8'h30, 32'h0);
        axi_write(`REG_HI_TRIP, 32'h0000_1234, 4'h1);
        axi_read(`REG_HI_TRIP, 32'h0000_ff34);
        axi_write(`REG_HI_TRIP, 32'h0000_03e8, 4'hf);
        axi_write(`REG_HI_HYST, 32'h0000_0064, 4'hf);
        axi_write(`REG_LO_TRIP, 32'h0000_00c8, 4'hf);
        axi_write(`REG_LO_HYST, 32'h0000_0032, 4'hf);
        axi_write(`REG_MASK, 32'h0000_0002, 4'hf);
        do_meas(16'h03e9, 1'b1, 1'b0, 1'b0);
        check("irq_set", irq, 1'b1);
        axi_read(`REG_MEAS, 32'h0001_03e9);
        do_meas(16'h03b6, 1'b1, 1'b0, 1'b0);
        do_meas(16'h0384, 1'b0, 1'b0, 1'b0);
        axi_read(`REG_STATUS, 32'h0000_0003);
        axi_read(`REG_STATUS, 32'h0);
        check("irq_clear", irq, 1'b0);
        do_meas(16'h00c7, 1'b0, 1'b1, 1'b0);
        check("irq_masked", irq, 1'b0);
        do_meas(16'h00f0, 1'b0, 1'b1, 1'b0);
        do_meas(16'h00fa, 1'b0, 1'b0, 1'b0);
        axi_read(`REG_STATUS, 32'h0000_0005);
        axi_write(`REG_CTRL, 32'h0000_0405, 4'hf);
        do_meas(16'h03e9, 1'b0, 1'b1, 1'b0);
        // both alarms open drain: active high alarm releases its pin
        axi_write(`REG_CTRL, 32'h0000_040a, 4'hf);
        @(negedge clk);
        check("od_pins", {ahi, ahi_oe_n, alo, alo_oe_n}, 4'h4);
        axi_write(`REG_CTRL, 32'h0000_0480, 4'hf);
        do_meas(16'h01f4, 1'b0, 1'b0, 1'b1);
        // update bit left clear: only density selection may force it on
        for (int s = 0; s < 4; s++) begin
            axi_write(`REG_CTRL, {22'h0, s[1:0], 8'h10}, 4'hf);
            @(negedge clk);
            check("density_pins", {dens, alo_oe_n}, {2{s >= 2}});
            check("update_mode", upd, s >= 2);
            check("diff_input", diff, 1'b1);
        end
        res = 4'($urandom);
        axi_write(`REG_RES, {28'h0, res}, 4'hf);
        @(negedge clk);
        check("resolution", {tres, cres}, res);
        axi_read(`REG_RES, {28'h0, res});
        axi_write(8'h40, 32'hffff_ffff, 4'hf);
        axi_read(8'h40, 32'h0);
        axi_read(`REG_CTRL, 32'h0000_0310);
        axi_write(`REG_CTRL, 32'h0000_0420, 4'hf);
        exp_level = 1'b1;
        ra = 7'($urandom);
        run_frame(ra, 1'b1);
        axi_write(`REG_CTRL, 32'h0000_0440, 4'hf);
        exp_level = 1'b0;
        ra = 7'($urandom);
        run_frame(ra, ra == 7'h28);
        run_frame(7'h28, 1'b1);
        final_report();
    end
endmodule : sensor_output_alarm_config_tb
